// ===== hw/cfg_protect_pkg.sv
/*
  Constants for the configuration decode and code protection block:
  register indices, field positions, block boundaries, reset values.
  Assumes a byte-addressed Avalon-MM bus with 32-bit data.
*/
package cfg_protect_pkg;

  // Register indices; byte address is four times the index
  localparam logic [21:0] CFG_IDX     = 22'h300006;
  localparam logic [21:0] PROT_IDX    = 22'h300010;
  localparam logic [21:0] PROBE_A_IDX = 22'h300011;
  localparam logic [21:0] PROBE_S_IDX = 22'h300012;
  localparam logic [21:0] VERDICT_IDX = 22'h300013;

  // Configuration byte fields
  localparam int DBG_BIT = 7;
  localparam int XI_BIT  = 6;
  localparam int BSZ_HI  = 5;
  localparam int BSZ_LO  = 4;
  localparam int SSP_BIT = 2;
  localparam int SFR_BIT = 0;
  localparam logic [7:0] CFG_IMPL_MASK = 8'hF5;
  localparam logic [7:0] CFG_RST       = 8'h00;

  // Boot block size codes and end addresses
  localparam logic [1:0]  BSZ_1K      = 2'h0;
  localparam logic [1:0]  BSZ_2K      = 2'h1;
  localparam logic [20:0] BOOT_END_1K = 21'h000800;
  localparam logic [20:0] BOOT_END_2K = 21'h001000;
  localparam logic [20:0] BOOT_END_4K = 21'h002000;

  // Program memory layout
  localparam int          BLK_LSB  = 14;
  localparam int          NBLK     = 7;
  localparam logic [2:0]  BOOT_BLK = 3'h0;
  localparam logic [2:0]  BLK_BASE = 3'h1;
  localparam logic [20:0] IMPL_END = 21'h018000;

  // Protection word: one bit per block in each group
  localparam int RP_LSB = 0;
  localparam int WL_LSB = 7;
  localparam int TP_LSB = 14;
  localparam logic [20:0] PROT_RST = 21'h000000;

  // Verdict register fields
  localparam int VD_TGT_LSB = 0;
  localparam int VD_SRC_LSB = 4;
  localparam int VD_UNIMPL  = 8;
  localparam int VD_RDENY   = 9;
  localparam int VD_WDENY   = 10;
  localparam int VD_TDENY   = 11;

endpackage

// ===== hw/config_code_protect_decode.sv
/*
  Configuration byte decode and program memory code protection.
  Latches the configuration byte and the protection bits from
  non-volatile storage after reset, drives the decoded controls,
  checks table reads, and offers an Avalon-MM register slave.
  Assumes nv_* inputs are static levels from storage outside this
  clock domain; tbl_* and stack_fault come from core logic on mclk.
*/
// Implementation choice: register access over Avalon-MM.
// Functional notes
// - Bit 7 one: debugger off, pins GPIO
// - Bit 6 enables extended set, indexed addressing
// - Bits 5:4 select 4K, 2K, 1K words
// - Bit 2 enables single-supply serial programming
// - Bit 0 lets stack faults reset
// - Bits 3 and 1 read zero
// - Five-plus blocks, boot block at zero
// - Later blocks start on 16K boundaries
// - Each block: read, write, table protect
`timescale 1ns/10ps
`default_nettype none

module config_code_protect_decode (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Non-volatile storage image
  input  wire logic [7:0]  nv_cfg,
  input  wire logic [20:0] nv_prot,
  // Avalon-MM slave
  input  wire logic [23:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Decoded controls
  output logic             debug_pins_dedicated,
  output logic             monitor_pins_gpio,
  output logic             extended_isa_on,
  output logic             boot_size_hi,
  output logic             boot_size_lo,
  output logic             single_supply_prog_on,
  output logic             stack_fault_reset_on,
  // Stack fault from the core
  input  wire logic        stack_fault,
  output logic             stack_reset,
  // Table read check
  input  wire logic        tbl_req,
  input  wire logic [20:0] tbl_addr,
  input  wire logic [20:0] tbl_src,
  input  wire logic [7:0]  tbl_data_in,
  output logic             tbl_valid,
  output logic      [7:0]  tbl_data,
  output logic             tbl_denied
);

  typedef enum logic [1:0] {
    SETTLE_A,
    SETTLE_B,
    CAPTURE,
    RUN
  } load_t;

  typedef struct packed {
    logic [7:0]  cfg_s1;
    logic [7:0]  cfg_s2;
    logic [20:0] prot_s1;
    logic [20:0] prot_s2;
    load_t       st;
    logic [7:0]  cfg;
    logic [20:0] prot;
    logic [20:0] probe_a;
    logic [20:0] probe_s;
    logic        ack;
    logic        waitreq;
    logic [31:0] rdata;
    logic        dbg_ded;
    logic        gpio;
    logic        xisa;
    logic        bsz_hi;
    logic        bsz_lo;
    logic        ssp;
    logic        sfr;
    logic        stk_rst;
    logic        t_valid;
    logic [7:0]  t_data;
    logic        t_denied;
  } state_t;

  state_t r;
  state_t nxt;

  // End of the boot block for the selected size
  function automatic logic [20:0] boot_end(input logic [1:0] code);
    logic [20:0] e;
    if (code == cfg_protect_pkg::BSZ_1K) begin
      e = cfg_protect_pkg::BOOT_END_1K;
    end else if (code == cfg_protect_pkg::BSZ_2K) begin
      e = cfg_protect_pkg::BOOT_END_2K;
    end else begin
      e = cfg_protect_pkg::BOOT_END_4K;
    end
    return e;
  endfunction

  // Block number: boot block 0, then one block per 16K boundary
  function automatic logic [2:0] blk_of(input logic [20:0] a,
                                        input logic [1:0]  code);
    logic [2:0] b;
    if (a < boot_end(code)) begin
      b = cfg_protect_pkg::BOOT_BLK;
    end else begin
      b = 3'(a[cfg_protect_pkg::BLK_LSB +: 3])
          + cfg_protect_pkg::BLK_BASE;
    end
    return b;
  endfunction

  function automatic logic unimpl(input logic [20:0] a);
    return a >= cfg_protect_pkg::IMPL_END;
  endfunction

  // One protection bit of a group; past the last block nothing is guarded
  function automatic logic prot_bit(input logic [20:0] p,
                                    input int          lsb,
                                    input logic [2:0]  blk);
    logic hit;
    hit = 1'b0;
    if (32'(blk) < cfg_protect_pkg::NBLK) begin
      hit = p[lsb + 32'(blk)];
    end
    return hit;
  endfunction

  // Table read blocked when issued from another block into a block whose table-protect bit is set
  function automatic logic tbl_block(input logic [20:0] a,
                                     input logic [20:0] s,
                                     input logic [1:0]  code,
                                     input logic [20:0] p);
    logic [2:0] tb;
    tb = blk_of(a, code);
    return (tb != blk_of(s, code))
           && prot_bit(p, cfg_protect_pkg::TP_LSB, tb);
  endfunction

  function automatic logic [20:0] merge21(input logic [20:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  be);
    logic [31:0] w;
    w = {11'h000, old};
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        w[8*i +: 8] = d[8*i +: 8];
      end
    end
    return w[20:0];
  endfunction

  logic [21:0] idx;
  logic        aligned;
  logic [1:0]  bsz;
  logic [2:0]  p_tgt;
  logic [2:0]  p_src;
  logic [31:0] verdict;

  assign idx     = address[23:2];
  assign aligned = (address[1:0] == 2'h0);
  assign bsz     = {r.cfg[cfg_protect_pkg::BSZ_HI], r.cfg[cfg_protect_pkg::BSZ_LO]};
  assign p_tgt   = blk_of(r.probe_a, bsz);
  assign p_src   = blk_of(r.probe_s, bsz);

  // Software-visible verdict for the probe address
  always_comb begin
    verdict = 32'h00000000;
    verdict[cfg_protect_pkg::VD_TGT_LSB +: 3] = p_tgt;
    verdict[cfg_protect_pkg::VD_SRC_LSB +: 3] = p_src;
    verdict[cfg_protect_pkg::VD_UNIMPL] = unimpl(r.probe_a);
    verdict[cfg_protect_pkg::VD_RDENY] =
      prot_bit(r.prot, cfg_protect_pkg::RP_LSB, p_tgt);
    verdict[cfg_protect_pkg::VD_WDENY] = unimpl(r.probe_a)
      || prot_bit(r.prot, cfg_protect_pkg::WL_LSB, p_tgt);
    verdict[cfg_protect_pkg::VD_TDENY] =
      tbl_block(r.probe_a, r.probe_s, bsz, r.prot);
  end

  always_comb begin
    nxt = r;
    // Storage image crosses in through two stages
    // Image is static while loading, so a plain word stage is safe
    nxt.cfg_s1  = nv_cfg;
    nxt.cfg_s2  = r.cfg_s1;
    nxt.prot_s1 = nv_prot;
    nxt.prot_s2 = r.prot_s1;

    // Settings taken once after reset, then frozen
    // Two settle edges let both stages fill before the capture
    case (r.st)
      SETTLE_A: begin
        nxt.st = SETTLE_B;
      end
      SETTLE_B: begin
        nxt.st = CAPTURE;
      end
      CAPTURE: begin
        nxt.cfg  = r.cfg_s2 & cfg_protect_pkg::CFG_IMPL_MASK;
        nxt.prot = r.prot_s2;
        nxt.st   = RUN;
      end
      default: begin
        nxt.st = RUN;
      end
    endcase

    // Decoded controls
    nxt.dbg_ded = ~r.cfg[cfg_protect_pkg::DBG_BIT];
    nxt.gpio    = r.cfg[cfg_protect_pkg::DBG_BIT];
    nxt.xisa    = r.cfg[cfg_protect_pkg::XI_BIT];
    nxt.bsz_hi  = r.cfg[cfg_protect_pkg::BSZ_HI];
    nxt.bsz_lo  = r.cfg[cfg_protect_pkg::BSZ_LO];
    nxt.ssp     = r.cfg[cfg_protect_pkg::SSP_BIT];
    nxt.sfr     = r.cfg[cfg_protect_pkg::SFR_BIT];
    nxt.stk_rst = stack_fault && r.cfg[cfg_protect_pkg::SFR_BIT]
                  && (r.st == RUN);

    // Table read: blocked or unimplemented reads return zero
    // Zero, not stale data, so nothing leaks from a guarded block
    nxt.t_valid  = tbl_req;
    nxt.t_denied = 1'b0;
    nxt.t_data   = 8'h00;
    if (tbl_req) begin
      nxt.t_denied = tbl_block(tbl_addr, tbl_src, bsz, r.prot);
      if (!unimpl(tbl_addr) && !nxt.t_denied) begin
        nxt.t_data = tbl_data_in;
      end
    end

    // Bus slave: one wait cycle, then answer
    // No retake while the answer stands; the master still holds it
    nxt.ack     = 1'b0;
    nxt.waitreq = 1'b1;
    if (r.st == RUN && (read || write) && !r.ack) begin
      nxt.ack     = 1'b1;
      nxt.waitreq = 1'b0;
      nxt.rdata   = 32'h00000000;
      if (read && aligned) begin
        if (idx == cfg_protect_pkg::CFG_IDX) begin
          nxt.rdata = {24'h000000, r.cfg};
        end else if (idx == cfg_protect_pkg::PROT_IDX) begin
          nxt.rdata = {11'h000, r.prot};
        end else if (idx == cfg_protect_pkg::PROBE_A_IDX) begin
          nxt.rdata = {11'h000, r.probe_a};
        end else if (idx == cfg_protect_pkg::PROBE_S_IDX) begin
          nxt.rdata = {11'h000, r.probe_s};
        end else if (idx == cfg_protect_pkg::VERDICT_IDX) begin
          nxt.rdata = verdict;
        end
      end
    end
    // Writes land on the edge the master sees waitrequest low
    if (r.ack && write && aligned) begin
      if (idx == cfg_protect_pkg::PROBE_A_IDX) begin
        nxt.probe_a = merge21(r.probe_a, writedata, byteenable);
      end else if (idx == cfg_protect_pkg::PROBE_S_IDX) begin
        nxt.probe_s = merge21(r.probe_s, writedata, byteenable);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r          <= '0;
      r.st       <= SETTLE_A;
      r.cfg      <= cfg_protect_pkg::CFG_RST;
      r.prot     <= cfg_protect_pkg::PROT_RST;
      r.waitreq  <= 1'b1;
      r.dbg_ded  <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  assign readdata              = r.rdata;
  assign waitrequest           = r.waitreq;
  assign debug_pins_dedicated  = r.dbg_ded;
  assign monitor_pins_gpio     = r.gpio;
  assign extended_isa_on       = r.xisa;
  assign boot_size_hi          = r.bsz_hi;
  assign boot_size_lo          = r.bsz_lo;
  assign single_supply_prog_on = r.ssp;
  assign stack_fault_reset_on  = r.sfr;
  assign stack_reset           = r.stk_rst;
  assign tbl_valid             = r.t_valid;
  assign tbl_data              = r.t_data;
  assign tbl_denied            = r.t_denied;

endmodule

`default_nettype wire

// ===== tb/config_code_protect_decode_props.sv
/*
  Port checker for config_code_protect_decode, bound into every instance.
  Assumes nv_cfg only changes while rst_n is low.
*/
`timescale 1ns/10ps
`default_nettype none
module cfg_decode_props (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Storage and bus
  input wire logic [7:0]  nv_cfg,
  input wire logic [23:0] address,
  input wire logic        read,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Decoded controls
  input wire logic        debug_pins_dedicated,
  input wire logic        monitor_pins_gpio,
  input wire logic        extended_isa_on,
  input wire logic        boot_size_hi,
  input wire logic        boot_size_lo,
  input wire logic        single_supply_prog_on,
  input wire logic        stack_fault_reset_on,
  input wire logic        stack_fault,
  input wire logic        stack_reset,
  // Table port
  input wire logic        tbl_req,
  input wire logic [20:0] tbl_addr,
  input wire logic        tbl_valid,
  input wire logic [7:0]  tbl_data,
  input wire logic        tbl_denied
);
  logic [2:0] cnt_r;
  logic       ready;
  // Settings are only trusted once the load has surely finished
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
    end else if (cnt_r != 3'h7) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
  assign ready = (cnt_r == 3'h7);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_dbg_pins: assert property (ready |->
    monitor_pins_gpio == nv_cfg[7] && debug_pins_dedicated == !nv_cfg[7])
    else $error("debug pin mode wrong");
  a_isa_mode: assert property (ready |-> extended_isa_on == nv_cfg[6])
    else $error("extended set control wrong");
  a_boot_size: assert property (ready |-> {boot_size_hi, boot_size_lo} == nv_cfg[5:4])
    else $error("boot size code wrong");
  a_ssp_mode: assert property (ready |-> single_supply_prog_on == nv_cfg[2])
    else $error("single supply control wrong");
  a_sfr_mode: assert property (ready |-> stack_fault_reset_on == nv_cfg[0])
    else $error("stack fault enable wrong");
  a_stack_rst: assert property (ready |=>
    stack_reset == ($past(stack_fault) && nv_cfg[0]))
    else $error("stack reset pulse wrong");
  a_cfg_read: assert property (read && !waitrequest && address == 24'hC00018 |->
    readdata == {24'h000000, nv_cfg & 8'hF5})
    else $error("config byte read wrong");
  a_deny_zero: assert property (tbl_valid && tbl_denied |-> tbl_data == 8'h00)
    else $error("denied table read leaks data");
  a_unimpl_zero: assert property (tbl_req && tbl_addr >= 21'h018000 |=>
    tbl_valid && tbl_data == 8'h00)
    else $error("unimplemented read not zero");
  a_hold_cfg: assert property (ready |=> $stable({monitor_pins_gpio,
    extended_isa_on, boot_size_hi, boot_size_lo, single_supply_prog_on}))
    else $error("settings changed in run");
  c_cfg_rd: cover property (read && !waitrequest && address == 24'hC00018);
  c_stack: cover property (stack_reset);
  c_deny: cover property (tbl_valid && tbl_denied);
endmodule
bind config_code_protect_decode cfg_decode_props chk (.mclk, .rst_n, .nv_cfg, .address,
  .read, .readdata, .waitrequest, .debug_pins_dedicated, .monitor_pins_gpio,
  .extended_isa_on, .boot_size_hi, .boot_size_lo, .single_supply_prog_on,
  .stack_fault_reset_on, .stack_fault, .stack_reset, .tbl_req, .tbl_addr, .tbl_valid,
  .tbl_data, .tbl_denied);
`default_nettype wire

// ===== tb/config_code_protect_decode_test.sv
/*
  Self-checking bench for config_code_protect_decode.
  Assumes the checker file is compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
module config_code_protect_decode_test;
  logic mclk, rst_n, read, write, waitrequest, stack_fault, stack_reset;
  logic debug_pins_dedicated, monitor_pins_gpio, extended_isa_on, boot_size_hi;
  logic boot_size_lo, single_supply_prog_on, stack_fault_reset_on;
  logic tbl_req, tbl_valid, tbl_denied;
  logic [7:0] nv_cfg, tbl_data_in, tbl_data, d;
  logic [20:0] nv_prot, tbl_addr, tbl_src, a, s;
  logic [20:0] al [8];
  logic [23:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, c;
  logic [31:0] q_bus [$];
  logic [9:0] q_tbl [$];
  logic [2:0] t, b;
  logic td;
  int err_total, n_compared, cyc;
  integer seed = 32'hB498D740;
  config_code_protect_decode uut (.mclk, .rst_n, .nv_cfg, .nv_prot, .address, .read,
    .write, .byteenable, .writedata, .readdata, .waitrequest, .debug_pins_dedicated,
    .monitor_pins_gpio, .extended_isa_on, .boot_size_hi, .boot_size_lo,
    .single_supply_prog_on, .stack_fault_reset_on, .stack_fault, .stack_reset, .tbl_req,
    .tbl_addr, .tbl_src, .tbl_data_in, .tbl_valid, .tbl_data, .tbl_denied);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic stop_test();
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_bus(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error readdata expected %h seen %h", e, g);
    end
  endtask
  // Top bit of the note says whether the denied flag is known
  task automatic chk_tbl(input logic [9:0] e, input logic [8:0] g);
    n_compared++;
    if (g[7:0] !== e[7:0] || (e[9] && g[8] !== e[8])) begin
      err_total++;
      $display("Error table result expected %h seen %h", e[8:0], g);
    end
  endtask
  task automatic bus(input logic [23:0] ad, input logic w, input logic [31:0] wd);
    address <= ad;
    read <= !w;
    write <= w;
    writedata <= wd;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [23:0] ad, input logic [31:0] e);
    q_bus.push_back(e);
    bus(ad, 1'b0, 32'h00000000);
  endtask
  function automatic logic [2:0] blk(input logic [20:0] x);
    logic [20:0] e;
    e = nv_cfg[5] ? 21'h002000 : nv_cfg[4] ? 21'h001000 : 21'h000800;
    if (x < e) return 3'h0;
    if (x < 21'h004000) return 3'h1;
    return 3'(x[16:14] + 3'h1);
  endfunction
  always @(posedge mclk) begin
    if (read === 1'b1 && waitrequest === 1'b0)
      chk_bus(q_bus.size() > 0 ? q_bus.pop_front() : 32'hFFFFFFFF, readdata);
    if (tbl_valid === 1'b1)
      chk_tbl(q_tbl.size() > 0 ? q_tbl.pop_front() : 10'h3FF, {tbl_denied, tbl_data});
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    {rst_n, read, write, stack_fault, tbl_req} = 5'h00;
    {address, writedata, nv_cfg, nv_prot} = '0;
    {tbl_addr, tbl_src, tbl_data_in} = '0;
    byteenable = 4'hF;
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    al = '{21'h0007FF, 21'h000800, 21'h000FFF, 21'h001000, 21'h001FFF, 21'h002000,
      21'h004000, 21'h017FFF};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      rst_n <= 1'b0;
      c = $random(seed);
      nv_cfg <= {c[7:6], 2'(i), c[3:0]};
      nv_prot <= 21'($random(seed));
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (8) @(posedge mclk);
      stack_fault <= 1'b1;
      @(posedge mclk);
      stack_fault <= 1'b0;
      bus(24'hC00018, 1'b1, 32'hFFFFFFFF);
      rd(24'hC00018, {24'h000000, nv_cfg & 8'hF5});
      rd(24'hC00040, {11'h000, nv_prot});
      rd(24'hC00020, 32'h00000000);
      for (int j = 0; j < 9; j++) begin
        a = j < 8 ? al[j] : 21'h018008;
        s = j[0] ? 21'($unsigned($random(seed))) % 21'h018000 : 21'h000000;
        d = 8'($random(seed));
        t = blk(a);
        b = blk(s);
        td = j < 8 && t != b && nv_prot[14 + 32'(t[2:0] % 3'h7)];
        q_tbl.push_back(j < 8 ? {1'b1, td, td ? 8'h00 : d} : 10'h000);
        tbl_req <= 1'b1;
        tbl_addr <= a;
        tbl_src <= s;
        tbl_data_in <= d;
        @(posedge mclk);
        tbl_req <= 1'b0;
        if (j < 8) begin
          bus(24'hC00044, 1'b1, {11'h000, a});
          bus(24'hC00048, 1'b1, {11'h000, s});
          rd(24'hC0004C, {20'h00000, td, nv_prot[7 + t], nv_prot[t], 2'h0, b, 1'b0, t});
        end
      end
      c = $random(seed);
      byteenable <= 4'h3;
      bus(24'hC00044, 1'b1, c);
      byteenable <= 4'hF;
      rd(24'hC00044, {11'h000, al[7][20:16], c[15:0]});
      rd(24'hC00019, 32'h00000000);
      repeat (2) @(posedge mclk);
    end
    stop_test();
  end
endmodule
`default_nettype wire
